// ===== logic/timer16_compare_dev.sv
// Output compare section of a 16-bit timer with its compare output unit.
//
// Notes on behaviour
// - Compare full counter with active value continuously.
// - Match sets flag one timer tick later.
// - Enabled flag requests interrupt; service clears flag.
// - Writing one to flag bit clears it.
// - Channel A compare value may set top.
// - Double buffer in PWM modes, direct otherwise.
// - Buffer loads active value at top only.
// - CPU reaches buffer when buffered, else active.
// - Only CPU changes compare; read back directly.
// - High byte to holding, low loads whole word.
// - Force strobe acts like match outside PWM modes, no flag.
// - Counter write blocks matches next timer tick.
// - Software avoids writing top or bottom badly.
// - Output state kept across mode changes.
// - New output action applies at next match.
// - Reset clears every output state to zero.
// - Nonzero action overrides port data; direction kept.
// - Software sets direction after preparing output state.
// - Output action never affects capture register.
// - Action zero leaves output state unchanged.
// - Match and bottom shape PWM output edges.
// - Clear-on-match action one toggles channel A.
// - Clear-on-match clears counter at its top.
`timescale 1ns/100ps
`default_nettype none
`include "timer16_regs.svh"
module timer16_compare_dev #(
   parameter int CHANNELS = 3
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   timer_bus_if.dev bus,
   input wire logic timerTick,
   output logic [CHANNELS-1:0] pinOut,
   output logic [CHANNELS-1:0] pinOe
);

   // =======================================================================
   // Mode decoding helpers.

   // Tells the twelve PWM modes from the normal and clear-on-match ones.
   function automatic logic isPwm(input timer16_pkg::wave_mode_t m);
      return !(m == `MODE_NORMAL || m == `MODE_CTC_CMPA ||
               m == `MODE_CTC_CAPT || m == `MODE_RESERVED);
   endfunction

   // Gives the counter top for a mode.
   function automatic logic [15:0] topOf(input timer16_pkg::wave_mode_t m,
                                         input logic [15:0] cmpA,
                                         input logic [15:0] capt);
      unique case (m)
         4'h1, 4'h5: return `TOP_8BIT;
         4'h2, 4'h6: return `TOP_9BIT;
         4'h3, 4'h7: return `TOP_10BIT;
         4'h4, 4'h9, 4'hB, 4'hF: return cmpA;
         4'h8, 4'hA, 4'hC, 4'hE: return capt;
         default: return `COUNT_MAX;
      endcase
   endfunction

   // Next output state for one channel from match, bottom and action.
   function automatic logic nextOut(input logic cur,
                                    input timer16_pkg::action_t act,
                                    input logic pwm,
                                    input logic hit,
                                    input logic bottom,
                                    input logic toggleOk);
      logic r;
      r = cur;
      if (hit && !pwm) begin
         unique case (act)
            2'd1: r = ~cur;
            2'd2: r = 1'b0;
            2'd3: r = 1'b1;
            default: r = cur;
         endcase
      end else if (hit) begin
         unique case (act)
            2'd1: r = toggleOk ? ~cur : cur;
            2'd2: r = 1'b0;
            2'd3: r = 1'b1;
            default: r = cur;
         endcase
      end else if (pwm && bottom) begin
         if (act == 2'd2) begin
            r = 1'b1;
         end else if (act == 2'd3) begin
            r = 1'b0;
         end
      end
      return r;
   endfunction

   // =======================================================================
   // Registers.
   logic [15:0] counterQ;
   logic [7:0] tempQ;
   logic [15:0] captQ;
   timer16_pkg::wave_mode_t modeQ;
   timer16_pkg::action_t actionQ [CHANNELS];
   logic [CHANNELS-1:0] irqEnQ;
   logic [CHANNELS-1:0] flagQ;
   logic [CHANNELS-1:0] portDataQ;
   logic [CHANNELS-1:0] pinDirQ;
   logic blockQ;
   logic [15:0] cmpBufQ [CHANNELS];
   logic [15:0] cmpActQ [CHANNELS];
   logic [CHANNELS-1:0] matchQ;
   logic [CHANNELS-1:0] outStateQ;
   logic [CHANNELS-1:0] irqQ;
   logic [7:0] rdataQ;
   logic [7:0] rdataD;
   logic [15:0] topValue;
   logic topHit;
   logic pwmMode;
   logic counterWr;
   logic [15:0] wrWord;

   assign pwmMode = isPwm(modeQ);
   assign topValue = topOf(modeQ, cmpActQ[0], captQ);
   assign topHit = (counterQ == topValue);
   assign wrWord = {tempQ, bus.busWdata};
   assign counterWr = bus.busWrite && bus.busAddr == `ADDR_COUNT_LO;

   // =======================================================================
   // Counter, holding register and loose control registers.

   // Counts on each timer tick; a CPU write always takes priority.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         counterQ <= `RESET_WORD;
      end else if (counterWr) begin
         counterQ <= wrWord;
      end else if (timerTick) begin
         if (topHit && modeQ != `MODE_NORMAL) begin
            counterQ <= `COUNT_BOTTOM;
         end else begin
            counterQ <= counterQ + 16'h0001;
         end
      end
   end

   // One holding register serves every 16-bit register of the timer.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         tempQ <= `RESET_BYTE;
      end else if (bus.busWrite && bus.busAddr[0] &&
                   bus.busAddr <= `ADDR_CAPT_HI) begin
         tempQ <= bus.busWdata;
      end else if (bus.busRead && bus.busAddr == `ADDR_COUNT_LO) begin
         tempQ <= counterQ[15:8];
      end else if (bus.busRead && bus.busAddr == `ADDR_CAPT_LO) begin
         tempQ <= captQ[15:8];
      end
   end

   // Capture word is written only in modes 8, 10, 12 and 14 (top source).
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         captQ <= `RESET_WORD;
      end else if (bus.busWrite && bus.busAddr == `ADDR_CAPT_LO &&
                   modeQ[3] && !modeQ[0]) begin
         captQ <= wrWord;
      end
   end

   // Mode, enables, port data and direction bits.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         modeQ <= `MODE_NORMAL;
         irqEnQ <= '0;
         portDataQ <= '0;
         pinDirQ <= '0;
      end else if (bus.busWrite) begin
         if (bus.busAddr == `ADDR_MODE) begin
            modeQ <= bus.busWdata[3:0];
         end
         if (bus.busAddr == `ADDR_IRQ_EN) begin
            irqEnQ <= bus.busWdata[CHANNELS-1:0];
         end
         if (bus.busAddr == `ADDR_PORT_DATA) begin
            portDataQ <= bus.busWdata[CHANNELS-1:0];
         end
         if (bus.busAddr == `ADDR_PIN_DIR) begin
            pinDirQ <= bus.busWdata[CHANNELS-1:0];
         end
      end
   end

   // Blocks matches from a counter write until the next timer tick.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         blockQ <= 1'b0;
      end else if (counterWr) begin
         blockQ <= 1'b1;
      end else if (timerTick) begin
         blockQ <= 1'b0;
      end
   end

   // =======================================================================
   // Per-channel compare, flag, output state and pin logic.
   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch++) begin : gChan
         localparam logic [7:0] LoAddr = 8'(`ADDR_CMPA_LO + 2 * ch);
         logic cmpWr;
         logic forceHit;
         logic hit;
         assign cmpWr = bus.busWrite && bus.busAddr == LoAddr;
         assign forceHit = bus.busWrite && bus.busAddr == `ADDR_FORCE &&
                           bus.busWdata[ch] && !pwmMode;
         assign hit = timerTick && matchQ[ch];

         // Output action is used live, never buffered with the compare.
         always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
               actionQ[ch] <= 2'd0;
            end else if (bus.busWrite && bus.busAddr == `ADDR_ACTION) begin
               actionQ[ch] <= bus.busWdata[2*ch +: 2];
            end
         end

         // Buffer and active compare words, changed only by the CPU.
         always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
               cmpBufQ[ch] <= `RESET_WORD;
               cmpActQ[ch] <= `RESET_WORD;
            end else if (cmpWr && !pwmMode) begin
               cmpBufQ[ch] <= wrWord;
               cmpActQ[ch] <= wrWord;
            end else begin
               if (cmpWr) begin
                  cmpBufQ[ch] <= wrWord;
               end
               if (pwmMode && timerTick && topHit) begin
                  cmpActQ[ch] <= cmpBufQ[ch];
               end
            end
         end

         // Equality is caught on a tick unless a counter write blocks it.
         always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
               matchQ[ch] <= 1'b0;
            end else if (timerTick) begin
               matchQ[ch] <= counterQ == cmpActQ[ch] && !blockQ;
            end
         end

         // Flag sets a tick after the match; a set beats any clear.
         always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
               flagQ[ch] <= 1'b0;
            end else if (hit) begin
               flagQ[ch] <= 1'b1;
            end else if (bus.irqAck[ch]) begin
               flagQ[ch] <= 1'b0;
            end else if (bus.busWrite && bus.busAddr == `ADDR_FLAGS &&
                         bus.busWdata[ch]) begin
               flagQ[ch] <= 1'b0;
            end
         end

         // Output state follows matches, force strobes and PWM top; mode changes keep it.
         always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
               outStateQ[ch] <= 1'b0;
            end else if (hit || forceHit || (timerTick && topHit)) begin
               outStateQ[ch] <= nextOut(outStateQ[ch], actionQ[ch], pwmMode,
                  hit || forceHit, timerTick && topHit,
                  ch == 0 && (modeQ == `MODE_FAST_CMPA || !pwmMode));
            end
         end

         // Interrupt request and pin drive, both registered.
         always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
               irqQ[ch] <= 1'b0;
               pinOut[ch] <= 1'b0;
               pinOe[ch] <= 1'b0;
            end else begin
               irqQ[ch] <= flagQ[ch] && irqEnQ[ch];
               pinOut[ch] <= (|actionQ[ch]) ? outStateQ[ch]
                                            : portDataQ[ch];
               pinOe[ch] <= pinDirQ[ch];
            end
         end
      end
   endgenerate

   // =======================================================================
   // Read path; compare bytes come back directly, not via holding.
   always_comb begin
      rdataD = 8'h00;
      unique case (bus.busAddr)
         `ADDR_COUNT_LO: rdataD = counterQ[7:0];
         `ADDR_COUNT_HI: rdataD = tempQ;
         `ADDR_CAPT_LO: rdataD = captQ[7:0];
         `ADDR_CAPT_HI: rdataD = tempQ;
         `ADDR_MODE: rdataD = {4'h0, modeQ};
         `ADDR_IRQ_EN: rdataD[CHANNELS-1:0] = irqEnQ;
         `ADDR_FLAGS: rdataD[CHANNELS-1:0] = flagQ;
         `ADDR_PORT_DATA: rdataD[CHANNELS-1:0] = portDataQ;
         `ADDR_PIN_DIR: rdataD[CHANNELS-1:0] = pinDirQ;
         default: rdataD = 8'h00;
      endcase
      for (int i = 0; i < CHANNELS; i++) begin
         if (bus.busAddr == 8'(`ADDR_CMPA_LO + 2 * i)) begin
            rdataD = pwmMode ? cmpBufQ[i][7:0] : cmpActQ[i][7:0];
         end
         if (bus.busAddr == 8'(`ADDR_CMPA_LO + 2 * i + 1)) begin
            rdataD = pwmMode ? cmpBufQ[i][15:8] : cmpActQ[i][15:8];
         end
         if (bus.busAddr == `ADDR_ACTION) begin
            rdataD[2*i +: 2] = actionQ[i];
         end
      end
   end

   // Read data is registered and holds until the next read.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rdataQ <= `RESET_BYTE;
      end else if (bus.busRead) begin
         rdataQ <= rdataD;
      end
   end

   assign bus.busRdata = rdataQ;
   assign bus.irqReq = irqQ;

endmodule // timer16_compare_dev
`default_nettype wire

// ===== logic/timer16_compare_host.sv
// CPU end: byte sequencing of 16-bit accesses and interrupt service.
`timescale 1ns/100ps
`default_nettype none
module timer16_compare_host #(
   parameter int CHANNELS = 3
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   timer_bus_if.cpu bus,
   input wire logic cmdValid,
   input wire logic cmdWrite,
   input wire logic cmdWide,
   input wire logic [7:0] cmdAddr,
   input wire logic [15:0] cmdData,
   output logic cmdReady,
   output logic rspValid,
   output logic [15:0] rspData,
   output logic [CHANNELS-1:0] irqSeen
);

   timer16_pkg::host_state_t stateQ;
   logic wideQ;
   logic [7:0] addrQ;
   logic [7:0] lowQ;
   logic [CHANNELS-1:0] ackQ;
   logic [CHANNELS-1:0] ackPrevQ;

   // =======================================================================
   // Sequencer: high byte first on writes, low byte first on reads.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         stateQ <= timer16_pkg::HOST_IDLE;
         cmdReady <= 1'b1;
         rspValid <= 1'b0;
         rspData <= 16'h0000;
         bus.busWrite <= 1'b0;
         bus.busRead <= 1'b0;
         bus.busAddr <= 8'h00;
         bus.busWdata <= 8'h00;
         wideQ <= 1'b0;
         addrQ <= 8'h00;
         lowQ <= 8'h00;
      end else begin
         bus.busWrite <= 1'b0;
         bus.busRead <= 1'b0;
         rspValid <= 1'b0;
         unique case (stateQ)
            timer16_pkg::HOST_IDLE: begin
               if (cmdValid && cmdReady) begin
                  addrQ <= cmdAddr;
                  wideQ <= cmdWide;
                  lowQ <= cmdData[7:0];
                  if (cmdWrite && cmdWide) begin
                     bus.busWrite <= 1'b1;
                     bus.busAddr <= cmdAddr + 8'h01;
                     bus.busWdata <= cmdData[15:8];
                     cmdReady <= 1'b0;
                     stateQ <= timer16_pkg::HOST_WR_LOW;
                  end else if (cmdWrite) begin
                     bus.busWrite <= 1'b1;
                     bus.busAddr <= cmdAddr;
                     bus.busWdata <= cmdData[7:0];
                  end else begin
                     bus.busRead <= 1'b1;
                     bus.busAddr <= cmdAddr;
                     cmdReady <= 1'b0;
                     stateQ <= timer16_pkg::HOST_RD_LOW_WAIT;
                  end
               end
            end
            timer16_pkg::HOST_WR_LOW: begin
               bus.busWrite <= 1'b1;
               bus.busAddr <= addrQ;
               bus.busWdata <= lowQ;
               cmdReady <= 1'b1;
               stateQ <= timer16_pkg::HOST_IDLE;
            end
            timer16_pkg::HOST_RD_LOW_WAIT: begin
               stateQ <= timer16_pkg::HOST_RD_LOW_TAKE;
            end
            timer16_pkg::HOST_RD_LOW_TAKE: begin
               if (wideQ) begin
                  lowQ <= bus.busRdata;
                  bus.busRead <= 1'b1;
                  bus.busAddr <= addrQ + 8'h01;
                  stateQ <= timer16_pkg::HOST_RD_HIGH_WAIT;
               end else begin
                  rspValid <= 1'b1;
                  rspData <= {8'h00, bus.busRdata};
                  cmdReady <= 1'b1;
                  stateQ <= timer16_pkg::HOST_IDLE;
               end
            end
            timer16_pkg::HOST_RD_HIGH_WAIT: begin
               stateQ <= timer16_pkg::HOST_RD_HIGH_TAKE;
            end
            timer16_pkg::HOST_RD_HIGH_TAKE: begin
               rspValid <= 1'b1;
               rspData <= {bus.busRdata, lowQ};
               cmdReady <= 1'b1;
               stateQ <= timer16_pkg::HOST_IDLE;
            end
         endcase
      end
   end

   // =======================================================================
   // Services each request once; two quiet cycles let it drop first.
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ackQ <= '0;
         ackPrevQ <= '0;
         irqSeen <= '0;
      end else begin
         ackQ <= bus.irqReq & ~ackQ & ~ackPrevQ;
         ackPrevQ <= ackQ;
         irqSeen <= bus.irqReq & ~ackQ & ~ackPrevQ;
      end
   end

   assign bus.irqAck = ackQ;

endmodule // timer16_compare_host
`default_nettype wire

// ===== logic/timer16_pkg.sv
// Types shared by both ends of the timer compare link.
`default_nettype none
package timer16_pkg;
   typedef logic [3:0] wave_mode_t;
   typedef logic [1:0] action_t;
   typedef enum logic [2:0] {
      HOST_IDLE,
      HOST_WR_LOW,
      HOST_RD_LOW_WAIT,
      HOST_RD_LOW_TAKE,
      HOST_RD_HIGH_WAIT,
      HOST_RD_HIGH_TAKE
   } host_state_t;
endpackage
`default_nettype wire

// ===== logic/timer16_regs.svh
// Register offsets, field positions, reset values and counts of the timer.
`ifndef TIMER16_REGS_SVH
`define TIMER16_REGS_SVH

// ==========================================================================
// Register offsets on the 8-bit bus.
`define ADDR_COUNT_LO 8'h00
`define ADDR_COUNT_HI 8'h01
`define ADDR_CMPA_LO 8'h02
`define ADDR_CAPT_LO 8'h08
`define ADDR_CAPT_HI 8'h09
`define ADDR_MODE 8'h0A
`define ADDR_ACTION 8'h0B
`define ADDR_FORCE 8'h0C
`define ADDR_IRQ_EN 8'h0D
`define ADDR_FLAGS 8'h0E
`define ADDR_PORT_DATA 8'h0F
`define ADDR_PIN_DIR 8'h10

// ==========================================================================
// Field positions, limits and reset values.
`define ACTION_FIELD_WIDTH 2
`define COUNT_MAX 16'hFFFF
`define COUNT_BOTTOM 16'h0000
`define TOP_8BIT 16'h00FF
`define TOP_9BIT 16'h01FF
`define TOP_10BIT 16'h03FF
`define MODE_NORMAL 4'h0
`define MODE_CTC_CMPA 4'h4
`define MODE_CTC_CAPT 4'hC
`define MODE_RESERVED 4'hD
`define MODE_FAST_CMPA 4'hF
`define RESET_BYTE 8'h00
`define RESET_WORD 16'h0000

`endif

// ===== logic/timer_bus_if.sv
// Byte-wide register bus and interrupt lines between CPU and timer.
`timescale 1ns/100ps
`default_nettype none
interface timer_bus_if #(parameter int CHANNELS = 3);
   logic busWrite;
   logic busRead;
   logic [7:0] busAddr;
   logic [7:0] busWdata;
   logic [7:0] busRdata;
   logic [CHANNELS-1:0] irqReq;
   logic [CHANNELS-1:0] irqAck;

   modport dev (input busWrite, busRead, busAddr, busWdata, irqAck,
                output busRdata, irqReq);
   modport cpu (output busWrite, busRead, busAddr, busWdata, irqAck,
                input busRdata, irqReq);
endinterface
`default_nettype wire

// ===== testbench/test_timer16_output_compare.sv
// Testbench joining the CPU end and the timer end of the compare link.
`timescale 1ns/100ps
`default_nettype none
`include "timer16_regs.svh"
module test_timer16_output_compare;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic timerTick = 1'b0;
   logic cmdValid = 1'b0;
   logic cmdWrite = 1'b0;
   logic cmdWide = 1'b0;
   logic [7:0] cmdAddr = 8'h00;
   logic [15:0] cmdData = 16'h0000;
   logic cmdReady;
   logic rspValid;
   logic [15:0] rspData;
   logic [15:0] rd;
   logic [2:0] irqSeen;
   logic [2:0] pinOut;
   logic [2:0] pinOe;
   logic gotIrq = 1'b0;
   logic modelOc = 1'b0;
   logic [15:0] modelCmp = 16'h0000;
   logic [31:0] seed = 32'h0000_0044;
   int fails = 0;
   int compares = 0;
   int cycles = 0;

   timer_bus_if #(.CHANNELS(3)) bus ();
   timer16_compare_dev #(.CHANNELS(3)) i_timer16_compare_dev (
      .sys_clk(sys_clk), .rst_n(rst_n), .bus(bus), .timerTick(timerTick),
      .pinOut(pinOut), .pinOe(pinOe));
   timer16_compare_host #(.CHANNELS(3)) i_timer16_compare_host (
      .sys_clk(sys_clk), .rst_n(rst_n), .bus(bus), .cmdValid(cmdValid),
      .cmdWrite(cmdWrite), .cmdWide(cmdWide), .cmdAddr(cmdAddr),
      .cmdData(cmdData), .cmdReady(cmdReady), .rspValid(rspValid),
      .rspData(rspData), .irqSeen(irqSeen));
   timer16_compare_props #(.CHANNELS(3)) i_timer16_compare_props (
      .sys_clk(sys_clk), .rst_n(rst_n), .busWrite(bus.busWrite),
      .busRead(bus.busRead), .busAddr(bus.busAddr),
      .busWdata(bus.busWdata), .busRdata(bus.busRdata),
      .irqReq(bus.irqReq), .irqAck(bus.irqAck));

   // =====================================================================
   // Clock, watchdog and interrupt service monitor.
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (irqSeen[0] === 1'b1) gotIrq <= 1'b1;
      if (cycles == 5000) begin
         fails++;
         report_and_stop();
      end
   end

   // =====================================================================
   // Helpers: random source, comparison, bus commands and timer ticks.
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic pin(input logic e);
      repeat (3) @(negedge sys_clk);
      check({15'h0000, pinOut[0]}, {15'h0000, e});
   endtask
   task automatic cmd(input logic w, input logic wd, input logic [7:0] a,
                      input logic [15:0] d);
      @(negedge sys_clk);
      cmdValid = 1'b1;
      cmdWrite = w;
      cmdWide = wd;
      cmdAddr = a;
      cmdData = d;
      while (cmdReady !== 1'b1) @(negedge sys_clk);
      @(negedge sys_clk);
      cmdValid = 1'b0;
      while ((w ? cmdReady : rspValid) !== 1'b1) @(negedge sys_clk);
      rd = rspData;
   endtask
   task automatic tick(input int n);
      repeat (n) begin
         @(negedge sys_clk);
         timerTick = 1'b1;
         @(negedge sys_clk);
         timerTick = 1'b0;
      end
   endtask
   // Loads the counter and runs to one tick past the match.
   task automatic hit(input logic [15:0] start, input logic nextOc);
      cmd(1'b1, 1'b1, `ADDR_COUNT_LO, start);
      tick(int'(modelCmp - start) + 1);
      pin(modelOc);
      tick(1);
      modelOc = nextOc;
      pin(modelOc);
   endtask
   task automatic flags(input logic [7:0] e);
      cmd(1'b0, 1'b0, `ADDR_FLAGS, 16'h0000);
      check({8'h00, rd[7:0]}, {8'h00, e});
   endtask
   task automatic report_and_stop();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // =====================================================================
   // Main sequence.
   initial begin
      repeat (8) @(posedge sys_clk);
      @(negedge sys_clk);
      rst_n = 1'b1;
      check({10'h000, pinOut, pinOe}, 16'h0000);
      seed = xs(seed);
      cmd(1'b1, 1'b1, `ADDR_CMPA_LO, seed[15:0]);
      cmd(1'b0, 1'b1, `ADDR_CMPA_LO, 16'h0000);
      check(rd, seed[15:0]);
      seed = xs(seed);
      cmd(1'b1, 1'b0, `ADDR_PORT_DATA, {13'h0000, seed[2:0]});
      cmd(1'b1, 1'b0, `ADDR_PIN_DIR, 16'h0007);
      pin(seed[0]);
      check({10'h000, pinOut, pinOe}, {10'h000, seed[2:0], 3'h7});
      cmd(1'b1, 1'b0, `ADDR_ACTION, 16'h0001);
      pin(modelOc);
      modelCmp = 16'h0040;
      cmd(1'b1, 1'b1, `ADDR_CMPA_LO, modelCmp);
      cmd(1'b1, 1'b0, `ADDR_IRQ_EN, 16'h0001);
      hit(16'h003C, ~modelOc);
      check({15'h0000, gotIrq}, 16'h0001);
      flags(8'h00);
      cmd(1'b1, 1'b0, `ADDR_IRQ_EN, 16'h0000);
      cmd(1'b1, 1'b1, `ADDR_COUNT_LO, modelCmp);
      tick(3);
      pin(modelOc);
      flags(8'h00);
      hit(16'h003E, ~modelOc);
      flags(8'h01);
      cmd(1'b1, 1'b0, `ADDR_FLAGS, 16'h0001);
      flags(8'h00);
      cmd(1'b1, 1'b0, `ADDR_ACTION, 16'h0000);
      cmd(1'b1, 1'b1, `ADDR_COUNT_LO, 16'h003E);
      tick(4);
      cmd(1'b1, 1'b0, `ADDR_ACTION, 16'h0001);
      pin(modelOc);
      flags(8'h01);
      cmd(1'b1, 1'b0, `ADDR_FLAGS, 16'h0001);
      cmd(1'b1, 1'b0, `ADDR_FORCE, 16'h0001);
      modelOc = ~modelOc;
      pin(modelOc);
      flags(8'h00);
      cmd(1'b1, 1'b0, `ADDR_ACTION, 16'h0002);
      pin(modelOc);
      hit(16'h003E, 1'b0);
      cmd(1'b1, 1'b0, `ADDR_ACTION, 16'h0003);
      cmd(1'b1, 1'b0, `ADDR_FORCE, 16'h0001);
      modelOc = 1'b1;
      pin(modelOc);
      cmd(1'b1, 1'b0, `ADDR_MODE, {12'h000, `MODE_CTC_CMPA});
      pin(modelOc);
      // Clear-on-match wraps at compare A; PWM defers a new compare to top.
      cmd(1'b1, 1'b1, `ADDR_COUNT_LO, modelCmp - 16'h0001);
      tick(2);
      cmd(1'b0, 1'b1, `ADDR_COUNT_LO, 16'h0000);
      check(rd, `COUNT_BOTTOM);
      cmd(1'b1, 1'b0, `ADDR_MODE, {12'h000, `MODE_FAST_CMPA});
      cmd(1'b1, 1'b1, `ADDR_CMPA_LO, 16'h0010);
      cmd(1'b0, 1'b1, `ADDR_CMPA_LO, 16'h0000);
      check(rd, 16'h0010);
      tick(17);
      cmd(1'b0, 1'b1, `ADDR_COUNT_LO, 16'h0000);
      check(rd, 16'h0011);
      tick(65);
      cmd(1'b0, 1'b1, `ADDR_COUNT_LO, 16'h0000);
      check(rd, `COUNT_BOTTOM);
      report_and_stop();
   end
endmodule // test_timer16_output_compare
`default_nettype wire

// ===== testbench/timer16_compare_props.sv
// Checker for the byte bus and interrupt lines between the two ends.
`timescale 1ns/100ps
`default_nettype none
module timer16_compare_props #(
   parameter int CHANNELS = 3
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic busWrite,
   input wire logic busRead,
   input wire logic [7:0] busAddr,
   input wire logic [7:0] busWdata,
   input wire logic [7:0] busRdata,
   input wire logic [CHANNELS-1:0] irqReq,
   input wire logic [CHANNELS-1:0] irqAck
);
   // =====================================================================
   // Clocking and reset shared by every property.
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   // A wide write sends the high byte, then the low byte next cycle.
   sequence s_high;
      busWrite && busAddr[0] && busAddr < 8'h0A;
   endsequence
   sequence s_low;
      busWrite && busAddr == $past(busAddr) - 8'h01;
   endsequence
   property p_high_then_low;
      s_high |=> s_low;
   endproperty
   a_high_then_low: assert property (p_high_then_low)
      else $error("Low byte did not follow the high byte.");

   // Interrupt request is quiet straight after reset.
   property p_rst_quiet;
      $rose(rst_n) |-> irqReq == '0;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("Interrupt request high after reset.");

   // A raised channel 0 request is serviced, and service drops it.
   property p_rose_acked;
      $rose(irqReq[0]) |-> ##[1:2] irqAck[0];
   endproperty
   a_rose_acked: assert property (p_rose_acked)
      else $error("Interrupt request not serviced.");
   property p_ack_clears;
      irqAck[0] |-> ##[1:3] !irqReq[0];
   endproperty
   a_ack_clears: assert property (p_ack_clears)
      else $error("Service did not clear the request.");
   property p_ack_needs_req;
      (irqAck & ~irqReq) == '0;
   endproperty
   a_ack_needs_req: assert property (p_ack_needs_req)
      else $error("Service without a request.");

   // Read strobes are single pulses; read and write strobes never collide.
   property p_no_rw_clash;
      !(busWrite && busRead);
   endproperty
   a_no_rw_clash: assert property (p_no_rw_clash)
      else $error("Read and write strobes together.");
   property p_read_pulse;
      busRead |=> !busRead;
   endproperty
   a_read_pulse: assert property (p_read_pulse)
      else $error("Read strobe longer than one cycle.");

   // Read data and address change only with an access.
   property p_rdata_stands;
      !busRead |=> $stable(busRdata);
   endproperty
   a_rdata_stands: assert property (p_rdata_stands)
      else $error("Read data changed without a read.");
   property p_addr_holds;
      $changed(busAddr) |-> (busWrite || busRead);
   endproperty
   a_addr_holds: assert property (p_addr_holds)
      else $error("Address moved without an access.");
endmodule // timer16_compare_props
`default_nettype wire
